// ### ilv_irq_lvd.v
// interrupt flag/enable registers and digital low-voltage detector control
//
// Summary of operation
// - pin one edge field bits 3:2 encoding
// - pin zero edge field bits 1:0 encoding
// - bit 0 is global interrupt enable
// - converter flag bit 6, enable bit 3
// - pin flags bits 5:4, enables bits 2:1
// - unimplemented bits read as zero
// - three primary, two grouped registers merge
// - threshold code 000 selects sense pin
// - output flag high while voltage below threshold
// - detector enable powers the detector
// - reference on if detector, monitor or bit
// - sleep forces the detector off
// - low-volt irq flag set after fixed delay
// - low-volt flag set wakes from idle
// - grouped reg one flag/enable bit layout
// - request needs flag, enable, global; service clears
// - any set flag wakes sleep or idle
`timescale 1ns/1ps
`include "ilv_consts.vh"
`default_nettype none
module ilv_irq_lvd #(
  parameter DELAY_CYC = `ILV_DELAY_CYC
) (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst_n,
  // avalon-mm slave
  input  wire [3:0] avs_address,
  input  wire       avs_read,
  input  wire       avs_write,
  input  wire [7:0] avs_writedata,
  output reg  [7:0] avs_readdata,
  output reg        avs_waitrequest,
  // event sources
  input  wire       ext_pin_zero,
  input  wire       ext_pin_one,
  input  wire       converter_done,
  input  wire [3:0] timebase_events,
  input  wire [1:0] serial_events,
  input  wire [3:0] timer_events,
  input  wire       nv_write_done,
  input  wire       reset_voltage_monitor,
  input  wire       sleep_mode,
  input  wire       comparator_low,
  input  wire       irq_ack,
  // outputs to core and analog
  output reg  [7:0] irq_request,
  output reg        wake_up,
  output reg        detector_on,
  output reg        reference_enable,
  output reg        sense_pin_select,
  output reg  [2:0] threshold_select
);

  //////////////////////////////////////////////////////////////////////////////
  function edge_hit;
    input [1:0] sel;
    input       cur;
    input       prev;
    begin
      case (sel)
        `ILV_EDGE_RISE: edge_hit = cur & ~prev;
        `ILV_EDGE_FALL: edge_hit = ~cur & prev;
        `ILV_EDGE_BOTH: edge_hit = cur ^ prev;
        default:        edge_hit = 1'b0;
      endcase
    end
  endfunction

  // next flag: hardware set wins over software clear
  function [3:0] flag_nxt;
    input [3:0] cur;
    input [3:0] hw;
    input       wr;
    input [3:0] wv;
    begin
      flag_nxt = (wr ? wv : cur) | hw;
    end
  endfunction

  // lowest index pending request wins the service acknowledge
  function [2:0] pick_lowest;
    input [6:0] req;
    begin
      if (req[0])      pick_lowest = 3'h0;
      else if (req[1]) pick_lowest = 3'h1;
      else if (req[2]) pick_lowest = 3'h2;
      else if (req[3]) pick_lowest = 3'h3;
      else if (req[4]) pick_lowest = 3'h4;
      else if (req[5]) pick_lowest = 3'h5;
      else             pick_lowest = 3'h6;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  reg  [7:0]  low_volt_detect_control_q;
  reg  [7:0]  edge_q;
  reg  [7:0]  pic0_q;
  reg  [7:0]  pic1_q;
  reg  [7:0]  pic2_q;
  reg  [7:0]  gic0_q;
  reg  [7:0]  gic1_q;
  reg  [1:0]  p0_sync_q;
  reg  [1:0]  p1_sync_q;
  reg         p0_prev_q;
  reg         p1_prev_q;
  reg  [1:0]  low_sync_q;
  reg         low_prev_q;
  reg  [31:0] dly_cnt_q;
  reg         dly_run_q;
  reg  [2:0]  svc_q;
  reg         svc_pend_q;

  wire        bus_go   = (avs_read | avs_write) & avs_waitrequest;
  // writes land on the edge that completes the transfer
  wire        wr_go    = avs_write & ~avs_waitrequest;
  wire        wr_low_volt_detect_control  = wr_go & (avs_address == `ILV_OFS_LOW_VOLT_DETECT_CONTROL);
  wire        wr_edge  = wr_go & (avs_address == `ILV_OFS_EDGE);
  wire        wr_pic0  = wr_go & (avs_address == `ILV_OFS_PIC0);
  wire        wr_pic1  = wr_go & (avs_address == `ILV_OFS_PIC1);
  wire        wr_pic2  = wr_go & (avs_address == `ILV_OFS_PIC2);
  wire        wr_gic0  = wr_go & (avs_address == `ILV_OFS_GIC0);
  wire        wr_gic1  = wr_go & (avs_address == `ILV_OFS_GIC1);
  wire [7:0]  wd       = avs_writedata;

  wire        det_on   = low_volt_detect_control_q[4] & ~sleep_mode;
  wire        low_now  = low_sync_q[1] & det_on;
  wire        dly_done = dly_run_q & (dly_cnt_q == DELAY_CYC - 1);

  wire        p0_ev    = edge_hit(edge_q[1:0], p0_sync_q[1], p0_prev_q);
  wire        p1_ev    = edge_hit(edge_q[3:2], p1_sync_q[1], p1_prev_q);

  // grouped requests merge into primary group flags
  wire        grp0_any = |(gic0_q[7:4] & gic0_q[3:0]);
  wire        grp1_any = |(gic1_q[5:4] & gic1_q[1:0]);

  wire [6:0]  req_vec;
  assign req_vec[0] = pic0_q[4] & pic0_q[1];
  assign req_vec[1] = pic0_q[5] & pic0_q[2];
  assign req_vec[2] = pic0_q[6] & pic0_q[3];
  assign req_vec[3] = pic1_q[4] & pic1_q[0];
  assign req_vec[4] = pic1_q[5] & pic1_q[1];
  assign req_vec[5] = |(pic1_q[7:6] & pic1_q[3:2]);
  assign req_vec[6] = |(pic2_q[5:4] & pic2_q[1:0]);

  // service acknowledge clears the global enable and, for requests 0 to 4 only, the flag of the lowest pending request
  wire        ack_now  = irq_ack & pic0_q[0] & (|req_vec);
  wire [2:0]  ack_idx  = pick_lowest(req_vec);
  wire        ack_p0   = ack_now & (ack_idx == 3'h0);
  wire        ack_p1   = ack_now & (ack_idx == 3'h1);
  wire        ack_ad   = ack_now & (ack_idx == 3'h2);
  wire        ack_g0   = ack_now & (ack_idx == 3'h3);
  wire        ack_g1   = ack_now & (ack_idx == 3'h4);

  // hardware set terms, also applied on top of an acknowledge clear
  wire [3:0]  pic0_hw  = {1'b0, converter_done, p1_ev, p0_ev};
  wire [3:0]  pic1_hw  = {timebase_events[1:0], grp1_any, grp0_any};
  wire [3:0]  pic2_hw  = {2'b00, serial_events};
  wire [3:0]  gic0_hw  = timer_events;
  wire [3:0]  gic1_hw  = {2'b00, nv_write_done, dly_done};

  wire [3:0]  pic0_f   = flag_nxt(pic0_q[7:4], pic0_hw,
                                  wr_pic0, {1'b0, wd[6:4]});
  wire [3:0]  pic1_f   = flag_nxt(pic1_q[7:4], pic1_hw,
                                  wr_pic1, wd[7:4]);
  wire [3:0]  pic2_f   = flag_nxt(pic2_q[7:4], pic2_hw,
                                  wr_pic2, wd[7:4] & 4'h3);
  wire [3:0]  gic0_f   = flag_nxt(gic0_q[7:4], gic0_hw, wr_gic0, wd[7:4]);
  wire [3:0]  gic1_f   = flag_nxt(gic1_q[7:4], gic1_hw,
                                  wr_gic1, wd[7:4] & 4'h3);

  //////////////////////////////////////////////////////////////////////////////
  // register file
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      low_volt_detect_control_q <= `ILV_RST8;
      edge_q <= `ILV_RST8;
      pic0_q <= `ILV_RST8;
      pic1_q <= `ILV_RST8;
      pic2_q <= `ILV_RST8;
      gic0_q <= `ILV_RST8;
      gic1_q <= `ILV_RST8;
    end else begin
      if (wr_low_volt_detect_control) begin
        low_volt_detect_control_q <= {3'b000, wd[4:0]};
      end
      if (wr_edge) begin
        edge_q <= wd & `ILV_EDGE_MASK;
      end
      pic0_q[7]   <= 1'b0;
      // a new event in the acknowledge cycle keeps its flag
      pic0_q[6:4] <= (pic0_f[2:0] & ~{ack_ad, ack_p1, ack_p0}) | pic0_hw[2:0];
      if (ack_now) begin
        pic0_q[0] <= 1'b0;
      end else if (wr_pic0) begin
        pic0_q[3:0] <= wd[3:0];
      end
      pic1_q[7:4] <= (pic1_f & ~{2'b00, ack_g1, ack_g0}) | pic1_hw;
      if (wr_pic1) begin
        pic1_q[3:0] <= wd[3:0];
      end
      pic2_q[7:4] <= pic2_f;
      if (wr_pic2) begin
        pic2_q[3:0] <= wd[3:0] & 4'h3;
      end
      gic0_q[7:4] <= gic0_f;
      if (wr_gic0) begin
        gic0_q[3:0] <= wd[3:0];
      end
      gic1_q[7:4] <= gic1_f;
      if (wr_gic1) begin
        gic1_q[3:0] <= wd[3:0] & 4'h3;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, comparator sync and irq delay
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      p0_sync_q  <= 2'b00;
      p1_sync_q  <= 2'b00;
      p0_prev_q  <= 1'b0;
      p1_prev_q  <= 1'b0;
      low_sync_q <= 2'b00;
      low_prev_q <= 1'b0;
      dly_cnt_q  <= 32'h0000_0000;
      dly_run_q  <= 1'b0;
    end else begin
      p0_sync_q  <= {p0_sync_q[0], ext_pin_zero};
      p1_sync_q  <= {p1_sync_q[0], ext_pin_one};
      p0_prev_q  <= p0_sync_q[1];
      p1_prev_q  <= p1_sync_q[1];
      low_sync_q <= {low_sync_q[0], comparator_low};
      low_prev_q <= low_now;
      // delay restarts on each rise, abandoned if the flag falls
      if (low_now & ~low_prev_q) begin
        dly_run_q <= 1'b1;
        dly_cnt_q <= 32'h0000_0000;
      end else if (!low_now || dly_done) begin
        dly_run_q <= 1'b0;
        dly_cnt_q <= 32'h0000_0000;
      end else if (dly_run_q) begin
        dly_cnt_q <= dly_cnt_q + 32'h0000_0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus answer: one wait cycle, then ack
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 8'h00;
    end else begin
      // one wait state per request, then back to high
      if (bus_go) begin
        avs_waitrequest <= 1'b0;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (bus_go && avs_read) begin
        case (avs_address)
          `ILV_OFS_LOW_VOLT_DETECT_CONTROL: avs_readdata <= {2'b00, low_now, low_volt_detect_control_q[4:0]};
          `ILV_OFS_EDGE: avs_readdata <= edge_q & `ILV_EDGE_MASK;
          `ILV_OFS_PIC0: avs_readdata <= pic0_q & `ILV_PIC0_MASK;
          `ILV_OFS_PIC1: avs_readdata <= pic1_q;
          `ILV_OFS_PIC2: avs_readdata <= pic2_q & `ILV_PIC2_MASK;
          `ILV_OFS_GIC0: avs_readdata <= gic0_q;
          `ILV_OFS_GIC1: avs_readdata <= gic1_q & `ILV_GIC1_MASK;
          default:       avs_readdata <= 8'h00;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered outputs to core and analog
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_request      <= 8'h00;
      wake_up          <= 1'b0;
      detector_on      <= 1'b0;
      reference_enable <= 1'b0;
      sense_pin_select <= 1'b1;
      threshold_select <= 3'h0;
    end else begin
      irq_request      <= {1'b0, req_vec & {7{pic0_q[0]}}};
      wake_up          <= |{pic0_q[6:4], pic1_q[7:4], pic2_q[5:4],
                            gic0_q[7:4], gic1_q[5:4]};
      detector_on      <= det_on;
      reference_enable <= low_volt_detect_control_q[4] | reset_voltage_monitor | low_volt_detect_control_q[3];
      sense_pin_select <= (low_volt_detect_control_q[2:0] == `ILV_THR_PIN);
      threshold_select <= low_volt_detect_control_q[2:0];
    end
  end

endmodule // ilv_irq_lvd
`default_nettype wire

// ### ilv_consts.vh
// register offsets, field positions and timing constants for the irq and low-voltage block
`ifndef ILV_CONSTS_VH
`define ILV_CONSTS_VH
`define ILV_OFS_LOW_VOLT_DETECT_CONTROL      4'h0
`define ILV_OFS_EDGE      4'h1
`define ILV_OFS_PIC0      4'h2
`define ILV_OFS_PIC1      4'h3
`define ILV_OFS_PIC2      4'h4
`define ILV_OFS_GIC0      4'h5
`define ILV_OFS_GIC1      4'h6
`define ILV_OFS_SVC       4'h7
`define ILV_RST8          8'h00
`define ILV_EDGE_OFF      2'h0
`define ILV_EDGE_RISE     2'h1
`define ILV_EDGE_FALL     2'h2
`define ILV_EDGE_BOTH     2'h3
`define ILV_THR_PIN       3'h0
`define ILV_LOW_VOLT_DETECT_CONTROL_MASK     8'h1F
`define ILV_EDGE_MASK     8'h0F
`define ILV_PIC0_MASK     8'h7F
`define ILV_PIC2_MASK     8'h33
`define ILV_GIC1_MASK     8'h33
`define ILV_DELAY_NS      1000
`define ILV_CLK_MHZ       250
`define ILV_DELAY_CYC     ((`ILV_DELAY_NS * `ILV_CLK_MHZ) / 1000)
`endif

// ### ilv_irq_lvd_props.sv
// port-level checker for the irq and low-voltage block
`timescale 1ns/1ps
`default_nettype none
`include "ilv_consts.vh"
module ilv_irq_lvd_props #(
  parameter DELAY_CYC = 4
) (
  // clock, reset and bus
  input wire logic       clk_sys, rst_n, avs_read, avs_write, avs_waitrequest,
  input wire logic [3:0] avs_address,
  input wire logic [7:0] avs_readdata,
  // core and analog side
  input wire logic       sleep_mode, reset_voltage_monitor, irq_ack, wake_up,
  input wire logic       detector_on, reference_enable, sense_pin_select,
  input wire logic [7:0] irq_request,
  input wire logic [2:0] threshold_select
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  wait_ans_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  wait_idle_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("answer without request");
  edge_zero_a: assert property (avs_read && avs_waitrequest && avs_address == `ILV_OFS_EDGE
    |=> avs_readdata[7:4] == 4'h0) else $error("edge reg top bits set");
  ctrl_zero_a: assert property (avs_read && avs_waitrequest && avs_address == `ILV_OFS_PIC0
    |=> !avs_readdata[7]) else $error("control bit 7 set");
  sense_sel_a: assert property (sense_pin_select == (threshold_select == `ILV_THR_PIN))
    else $error("sense select wrong");
  sleep_off_a: assert property (sleep_mode |=> !detector_on)
    else $error("detector on in sleep");
  ref_det_a: assert property (detector_on |-> reference_enable)
    else $error("reference off with detector on");
  ref_mon_a: assert property (reset_voltage_monitor |=> reference_enable)
    else $error("reference off with monitor on");
  wake_req_a: assert property (|irq_request |-> wake_up)
    else $error("request without wake");
  ack_clr_a: assert property (irq_ack && |irq_request |-> ##2 irq_request == 8'h00)
    else $error("service left request");
  cover property (avs_write && !avs_waitrequest);
  cover property (irq_ack && |irq_request);
  cover property ($fell(detector_on));
endmodule // ilv_irq_lvd_props
bind ilv_irq_lvd ilv_irq_lvd_props #(.DELAY_CYC(DELAY_CYC)) ilv_irq_lvd_props_inst (
  .clk_sys, .rst_n, .avs_read, .avs_write, .avs_waitrequest, .avs_address, .avs_readdata,
  .sleep_mode, .reset_voltage_monitor, .irq_ack, .wake_up, .detector_on, .reference_enable,
  .sense_pin_select, .irq_request, .threshold_select);
`default_nettype wire

// ### ilv_core_model.sv
// core stand-in that services pending interrupt requests
`timescale 1ns/1ps
`default_nettype none
module ilv_core_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // request in, service pulse out
  input  wire logic [7:0] irq_request,
  input  wire logic       ack_en,
  output var  logic       irq_ack
);
  logic [1:0] gap_q;
  // one service per request, then a pause while the request line drains
  always @(posedge clk_sys) begin
    irq_ack <= rst_n && ack_en && (|irq_request) && !irq_ack && gap_q == 2'h0;
    gap_q   <= !rst_n ? 2'h0 : irq_ack ? 2'h3 : (gap_q != 2'h0) ? gap_q - 2'h1 : gap_q;
  end
endmodule // ilv_core_model
`default_nettype wire

// ### ilv_irq_lvd_tb_top.sv
// self-checking bench for the irq and low-voltage block
`timescale 1ns/1ps
`default_nettype none
`include "ilv_consts.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module ilv_irq_lvd_tb_top;
  localparam int DLY = 20;
  logic       clk_sys = 0, rst_n = 0, avs_read = 0, avs_write = 0, ack_en = 0;
  logic       ext_pin_zero = 0, ext_pin_one = 0, converter_done = 0, comparator_low = 0;
  logic       reset_voltage_monitor = 0, sleep_mode = 0;
  logic [3:0] avs_address = 4'h0;
  logic [7:0] avs_writedata = 8'h00, avs_readdata, irq_request, rd;
  logic       avs_waitrequest, irq_ack, wake_up, detector_on, reference_enable, sense_pin_select;
  logic [2:0] threshold_select;
  int         err_count = 0, tests_run = 0, cyc = 0;
  ilv_irq_lvd #(.DELAY_CYC(DLY)) ilv_irq_lvd_inst (.clk_sys, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .ext_pin_zero, .ext_pin_one,
    .converter_done, .timebase_events(4'h0), .serial_events(2'h0), .timer_events(4'h0),
    .nv_write_done(1'b0), .reset_voltage_monitor, .sleep_mode, .comparator_low, .irq_ack,
    .irq_request, .wake_up, .detector_on, .reference_enable, .sense_pin_select, .threshold_select);
  ilv_core_model ilv_core_model_inst (.clk_sys, .rst_n, .irq_request, .ack_en, .irq_ack);
  always #2 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      $display("[ERR] %0t timeout", $time);
      tally_and_finish();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // one bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(rd, e)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] m [7] = '{`ILV_LOW_VOLT_DETECT_CONTROL_MASK, `ILV_EDGE_MASK, `ILV_PIC0_MASK, 8'hFF,
                          `ILV_PIC2_MASK, 8'hFF, `ILV_GIC1_MASK};
    for (int i = 0; i < 7; i++) rchk(4'(i), `ILV_RST8);
    for (int i = 0; i < 7; i++) bus(1'b1, 4'(i), 8'hFF);
    for (int i = 0; i < 7; i++) rchk(4'(i), m[i]);
    `CHK(wake_up, 1'b1)
    bus(1'b1, 4'h9, 8'hFF);
    rchk(4'h9, 8'h00);
    for (int i = 6; i >= 0; i--) bus(1'b1, 4'(i), 8'h00);
    $display("t_regs done");
  endtask
  task automatic pin(input int p, input logic v);
    @(posedge clk_sys);
    if (p == 1) ext_pin_one <= v;
    else ext_pin_zero <= v;
    tick(4);
  endtask
  task automatic t_edge();
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 4; c++) begin
        bus(1'b1, `ILV_OFS_EDGE, 8'(c << (2 * p)));
        bus(1'b1, `ILV_OFS_PIC0, 8'h00);
        pin(p, 1'b1);
        rchk(`ILV_OFS_PIC0, 8'((c & 1) << (4 + p)));
        bus(1'b1, `ILV_OFS_PIC0, 8'h00);
        pin(p, 1'b0);
        rchk(`ILV_OFS_PIC0, 8'((c >> 1) << (4 + p)));
      end
    $display("t_edge done");
  endtask
  task automatic t_ack();
    bus(1'b1, `ILV_OFS_PIC0, 8'h48);
    tick(3);
    `CHK(irq_request, 8'h00)
    rchk(`ILV_OFS_PIC0, 8'h48);
    bus(1'b1, `ILV_OFS_PIC0, 8'h49);
    tick(2);
    `CHK(irq_request, 8'h04)
    ack_en <= 1'b1;
    bus(1'b1, `ILV_OFS_PIC0, 8'h13);
    tick(8);
    rchk(`ILV_OFS_PIC0, 8'h02);
    ack_en <= 1'b0;
    converter_done <= 1'b1;
    tick(1);
    converter_done <= 1'b0;
    tick(2);
    rchk(`ILV_OFS_PIC0, 8'h42);
    bus(1'b1, `ILV_OFS_PIC0, 8'h00);
    $display("t_ack done");
  endtask
  task automatic t_volt();
    bus(1'b1, `ILV_OFS_LOW_VOLT_DETECT_CONTROL, 8'h10);
    tick(2);
    `CHK({detector_on, reference_enable, sense_pin_select}, 3'b111)
    bus(1'b1, `ILV_OFS_GIC1, 8'h01);
    repeat (3) begin
      comparator_low <= 1'b1;
      tick(5);
      comparator_low <= 1'b0;
      tick(5);
    end
    rchk(`ILV_OFS_GIC1, 8'h01);
    comparator_low <= 1'b1;
    tick(4);
    rchk(`ILV_OFS_LOW_VOLT_DETECT_CONTROL, 8'h30);
    rchk(`ILV_OFS_GIC1, 8'h01);
    tick(DLY);
    rchk(`ILV_OFS_GIC1, 8'h11);
    `CHK(wake_up, 1'b1)
    sleep_mode <= 1'b1;
    tick(3);
    `CHK(detector_on, 1'b0)
    rchk(`ILV_OFS_LOW_VOLT_DETECT_CONTROL, 8'h10);
    sleep_mode <= 1'b0;
    bus(1'b1, `ILV_OFS_LOW_VOLT_DETECT_CONTROL, 8'h0D);
    tick(2);
    `CHK({detector_on, reference_enable, sense_pin_select, threshold_select}, 6'h15)
    bus(1'b1, `ILV_OFS_LOW_VOLT_DETECT_CONTROL, 8'h00);
    reset_voltage_monitor <= 1'b1;
    tick(2);
    `CHK({detector_on, reference_enable}, 2'b01)
    reset_voltage_monitor <= 1'b0;
    comparator_low <= 1'b0;
    bus(1'b1, `ILV_OFS_GIC1, 8'h11);
    tick(2);
    `CHK(wake_up, 1'b1)
    $display("t_volt done");
  endtask
  initial begin
    tick(20);
    rst_n <= 1'b1;
    t_regs();
    t_edge();
    t_ack();
    t_volt();
    tally_and_finish();
  end
endmodule // ilv_irq_lvd_tb_top
`default_nettype wire
